// [shared/ripc_pkg.sv]
// constants, modes and states for the rs-485 input port controller
// assumes a 20 MHz core clock and a plain strobed register port
package ripc_pkg;
   // ---------------------------------------------
   // geometry
   // ---------------------------------------------
   localparam int CLK_NS = 50;
   localparam int DATA_W = 32;
   localparam int HALF_W = 16;
   localparam int FIFO_DEPTH = 4096;
   localparam int LVL_W = 13;
   localparam int CTL_W = 8;
   localparam int TMR_W = 4;
   // ---------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------
   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_LEVEL = 4'h8;
   localparam logic [3:0] ADDR_WDATA = 4'hC;
   localparam logic [3:0] MODE_RESET = 4'h0;
   // ---------------------------------------------
   // mode codes
   // ---------------------------------------------
   localparam logic [3:0] MODE_CAMAC = 4'h0;
   localparam logic [3:0] MODE_TOKEN_PERMIT = 4'h1;
   localparam logic [3:0] MODE_TOKEN_FREE = 4'h2;
   localparam logic [3:0] MODE_PULL = 4'h3;
   localparam logic [3:0] MODE_LOOPBACK = 4'h4;
   localparam logic [3:0] MODE_RAW = 4'h5;
   localparam logic [3:0] MODE_SINGLE_GRANT = 4'h8;
   // ---------------------------------------------
   // status layout and control input indices
   // ---------------------------------------------
   localparam int ST_CTL_LSB = 0;
   localparam int ST_STATE_LSB = 8;
   localparam int ST_OVF_BIT = 11;
   localparam int ST_RXEN_BIT = 12;
   localparam int CTL_EOR = 0;
   localparam int CTL_PERMIT = 1;
   localparam int CTL_STROBE = 2;
   localparam int CTL_EMPTY = 3;
   localparam int CTL_AUX_LSB = 4;
   localparam logic [DATA_W-1:0] EOR_MARK = 32'h8000_0000;
   // ---------------------------------------------
   // timing
   // ---------------------------------------------
   localparam int PERMIT_NS = 400;
   localparam int PULL_LOW_NS = 400;
   localparam int PERMIT_CYC = (PERMIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULL_LOW_CYC = (PULL_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULL_GAP_CYC = 4;
   localparam logic [LVL_W-1:0] WAIT_LEVEL = 13'h0FF8;
   localparam logic [LVL_W-1:0] LOOP_LEVEL = 13'h0FFE;
   localparam logic [TMR_W-1:0] TMR_ZERO = 4'h0;
   localparam logic [TMR_W-1:0] TMR_ONE = 4'h1;

   typedef enum logic [3:0] {
      ST_IDLE, ST_PERMIT, ST_XFER, ST_WAIT, ST_PULL, ST_PULL_LOW,
      ST_PULL_GAP, ST_LOOP, ST_HOLD
   } ripc_state_e;
endpackage : ripc_pkg

// [core/ripc_fifo.sv]
// flip-flop fifo with registered output stage
// assumes one clock; both sides use valid/ready
`timescale 1ns/10ps
module ripc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8,
   parameter int LVL_W = 4
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i,
   output logic [LVL_W-1:0] level_o
);
   localparam int PTR_W = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wp_q, rp_q;
   logic [LVL_W-1:0] cnt_q;
   logic push, load;

   assign in_ready_o = (cnt_q != LVL_W'(DEPTH));
   assign push = in_valid_i & in_ready_o;
   // refill the output stage whenever it is empty or being taken
   assign load = (cnt_q != '0) & (~out_valid_o | out_ready_i);
   assign level_o = cnt_q;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wp_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= PTR_W'(wp_q + 1'b1);
         end
         if (load) begin
            rp_q <= PTR_W'(rp_q + 1'b1);
         end
         cnt_q <= LVL_W'(cnt_q + push - load);
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end else if (load) begin
         out_valid_o <= 1'b1;
         out_data_o <= mem_q[rp_q];
      end else if (out_ready_i) begin
         out_valid_o <= 1'b0;
      end
   end
endmodule : ripc_fifo

// [core/ripc_ctrl.sv]
// rs-485 input port controller: write side of the shared fifo
// assumes link pins are asynchronous to ref_clk_i; ecl loopback and
// the fifo read side are on ref_clk_i
//
// Operation
// R1 - incoming words are buffered in a 4K x 32-bit fifo
// R2 - this block owns only the fifo write side; the reader drains it
// R3 - writes come from rs-485 link, register port, or ecl loopback
// R4 - stored data is offered to readout or the rs-485 output port
// R5 - token modes idle in transfer state; each strobe edge writes one word
// R6 - end of record writes one marker word into the fifo
// R7 - permit mode waits for permit in before returning to state zero
// R8 - pull mode drives both fifo write and link strobe
// R9 - pull mode keeps writing until the source empty flag is true
// R10 - mode 0 disables controller and receivers; only register writes
// R11 - mode 1 pulses permit out first, then waits permit in per record
// R12 - mode 2 never pulses permit out and ignores permit in
// R13 - mode 3 fills fifo by pulling while watching source empty flag
// R14 - mode 4 writes ecl 16-bit data duplicated into both halves
// R15 - mode 5 as mode 1, no wait, end of record ignored, inputs readable
// R16 - mode 8 as mode 1 but halts in state zero after permit in
// R17 - software writes mode 0 then mode 8 for another permit out
// R18 - each entry into mode 8 sends a fresh permit out
// R19 - reserved modes behave as disabled; here they also refuse register writes, which only mode 0 accepts
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/10ps
module ripc_ctrl
   import ripc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   input wire logic [DATA_W-1:0] src_data_i,
   input wire logic src_strobe_i,
   input wire logic end_of_record_i,
   input wire logic permit_in_i,
   input wire logic source_empty_flag_i,
   input wire logic [3:0] aux_ctrl_i,
   output logic strobe_o,
   output logic permit_out_o,
   output logic wait_o,
   output logic rx_enable_o,
   input wire logic [HALF_W-1:0] ecl_data_i,
   input wire logic ecl_valid_i,
   output logic ecl_ready_o,
   output logic [DATA_W-1:0] fifo_rd_data_o,
   output logic fifo_rd_valid_o,
   input wire logic fifo_rd_ready_i
);
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic uses_permit(input logic [3:0] m);
      return (m == MODE_TOKEN_PERMIT) || (m == MODE_RAW) || (m == MODE_SINGLE_GRANT);
   endfunction : uses_permit

   function automatic logic rx_on(input logic [3:0] m);
      return uses_permit(m) || (m == MODE_TOKEN_FREE) || (m == MODE_PULL);
   endfunction : rx_on

   function automatic logic [2:0] state_code(input ripc_state_e s);
      unique case (s)
         ST_PERMIT: return 3'h1;
         ST_WAIT: return 3'h2;
         ST_XFER, ST_LOOP: return 3'h3;
         ST_PULL, ST_PULL_LOW, ST_PULL_GAP: return 3'h4;
         ST_IDLE, ST_HOLD: return 3'h0;
      endcase
   endfunction : state_code

   logic [3:0] mode_q;
   ripc_state_e st_q;
   logic [TMR_W-1:0] tmr_q;
   logic [DATA_W-1:0] data_s1_q, data_s2_q;
   logic [CTL_W-1:0] ctl_in, ctl_s1_q, ctl_s2_q, ctl_d3_q;
   logic eor_pend_q, ovf_q, strobe_q, permit_q, wait_q, rxen_q, ecl_rdy_q;
   logic [DATA_W-1:0] rdata_q;
   logic mode_wr, cam_wr, strb_fall, eor_rise, permit_rise, empty_s;
   logic eor_take, wr_req, in_rdy;
   logic [DATA_W-1:0] wr_data;
   logic [LVL_W-1:0] lvl;

   // ---------------------------------------------
   // link input synchronisers
   // ---------------------------------------------
   assign ctl_in = {aux_ctrl_i, source_empty_flag_i, src_strobe_i,
                    permit_in_i, end_of_record_i};

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_s1_q <= '0;
         data_s2_q <= '0;
         ctl_s1_q <= '0;
         ctl_s2_q <= '0;
         ctl_d3_q <= '0;
      end else begin
         data_s1_q <= src_data_i;
         data_s2_q <= data_s1_q;
         ctl_s1_q <= ctl_in;
         ctl_s2_q <= ctl_s1_q;
         ctl_d3_q <= ctl_s2_q;
      end
   end

   // strobe is active on its falling edge; data is held well past it
   assign strb_fall = ctl_d3_q[CTL_STROBE] & ~ctl_s2_q[CTL_STROBE];
   assign eor_rise = ~ctl_d3_q[CTL_EOR] & ctl_s2_q[CTL_EOR];
   assign permit_rise = ~ctl_d3_q[CTL_PERMIT] & ctl_s2_q[CTL_PERMIT];
   assign empty_s = ctl_s2_q[CTL_EMPTY];

   // ---------------------------------------------
   // mode register
   // ---------------------------------------------
   assign mode_wr = reg_we_i & (reg_addr_i == ADDR_MODE);
   assign cam_wr = reg_we_i & (reg_addr_i == ADDR_WDATA) & (mode_q == MODE_CAMAC); // R10

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_q <= MODE_RESET;
      end else if (mode_wr) begin
         mode_q <= reg_wdata_i[3:0];
      end
   end

   // ---------------------------------------------
   // state machine
   // ---------------------------------------------
   // any mode write restarts from state zero, so re-entering mode 8
   // always passes through the permit pulse again
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_q <= ST_IDLE;
         tmr_q <= TMR_ZERO;
      end else if (mode_wr) begin
         st_q <= ST_IDLE; // R18
         tmr_q <= TMR_ZERO;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               if (uses_permit(mode_q)) begin
                  st_q <= ST_PERMIT; // R11 R15 R16 R18
                  tmr_q <= TMR_W'(PERMIT_CYC - 1);
               end else if (mode_q == MODE_TOKEN_FREE) begin
                  st_q <= ST_XFER; // R12
               end else if (mode_q == MODE_PULL) begin
                  st_q <= ST_PULL; // R13
               end else if (mode_q == MODE_LOOPBACK) begin
                  st_q <= ST_LOOP; // R14
               end
            end
            ST_PERMIT: begin
               if (tmr_q == TMR_ZERO) begin
                  st_q <= ST_XFER;
               end else begin
                  tmr_q <= tmr_q - TMR_ONE;
               end
            end
            ST_XFER: begin
               if (eor_take && uses_permit(mode_q)) begin
                  st_q <= ST_WAIT; // R7 R11
               end
            end
            ST_WAIT: begin
               if (permit_rise) begin
                  st_q <= (mode_q == MODE_SINGLE_GRANT) ? ST_HOLD : ST_IDLE; // R7 R16
               end
            end
            ST_PULL: begin
               if (empty_s) begin
                  st_q <= ST_HOLD; // R9
               end else if (in_rdy) begin
                  st_q <= ST_PULL_LOW;
                  tmr_q <= TMR_W'(PULL_LOW_CYC - 1);
               end
            end
            ST_PULL_LOW: begin
               if (tmr_q == TMR_ZERO) begin
                  st_q <= ST_PULL_GAP;
                  tmr_q <= TMR_W'(PULL_GAP_CYC - 1);
               end else begin
                  tmr_q <= tmr_q - TMR_ONE;
               end
            end
            ST_PULL_GAP: begin
               if (tmr_q == TMR_ZERO) begin
                  st_q <= ST_PULL; // R9
               end else begin
                  tmr_q <= tmr_q - TMR_ONE;
               end
            end
            ST_LOOP, ST_HOLD: begin
               st_q <= st_q;
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------
   // end of record capture
   // ---------------------------------------------
   // a strobe edge in the same cycle goes first; the marker follows
   assign eor_take = (st_q == ST_XFER) & eor_pend_q & ~strb_fall;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         eor_pend_q <= 1'b0;
      end else if (eor_rise && st_q == ST_XFER && mode_q != MODE_RAW) begin
         eor_pend_q <= 1'b1; // R6 R15
      end else if (eor_take || mode_wr) begin
         eor_pend_q <= 1'b0;
      end
   end

   // ---------------------------------------------
   // fifo write mux
   // ---------------------------------------------
   always_comb begin
      wr_req = 1'b0;
      wr_data = data_s2_q;
      if (cam_wr) begin
         wr_req = 1'b1; // R3 R10
         wr_data = reg_wdata_i;
      end else if (st_q == ST_XFER && strb_fall) begin
         wr_req = 1'b1; // R5
      end else if (eor_take) begin
         wr_req = 1'b1; // R6
         wr_data = EOR_MARK;
      end else if (st_q == ST_PULL_GAP && tmr_q == TMR_ZERO) begin
         wr_req = 1'b1; // R8
      end else if (st_q == ST_LOOP && ecl_valid_i && ecl_rdy_q) begin
         wr_req = 1'b1; // R14
         wr_data = {ecl_data_i, ecl_data_i};
      end
   end

   // R1 R2 R4: write side here, read side handed to the reader
   ripc_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH),
      .LVL_W(LVL_W)
   ) u_fifo (
      .clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(wr_req),
      .in_data_i(wr_data),
      .in_ready_o(in_rdy),
      .out_valid_o(fifo_rd_valid_o),
      .out_data_o(fifo_rd_data_o),
      .out_ready_i(fifo_rd_ready_i),
      .level_o(lvl)
   );

   // ---------------------------------------------
   // link outputs
   // ---------------------------------------------
   // registered one cycle after the state; widths are unchanged
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         strobe_q <= 1'b0;
         permit_q <= 1'b0;
         wait_q <= 1'b0;
         rxen_q <= 1'b0;
         ecl_rdy_q <= 1'b0;
      end else begin
         strobe_q <= (st_q == ST_PULL_LOW); // R8
         permit_q <= (st_q == ST_PERMIT); // R11 R12
         // wait leaves margin for words still in the synchroniser
         wait_q <= rx_on(mode_q) && mode_q != MODE_RAW && lvl >= WAIT_LEVEL; // R15
         rxen_q <= rx_on(mode_q); // R10 R19
         ecl_rdy_q <= (st_q == ST_LOOP) && lvl < LOOP_LEVEL && !wr_req;
      end
   end

   assign strobe_o = strobe_q;
   assign permit_out_o = permit_q;
   assign wait_o = wait_q;
   assign rx_enable_o = rxen_q;
   assign ecl_ready_o = ecl_rdy_q;

   // ---------------------------------------------
   // status and read port
   // ---------------------------------------------
   // overflow: a refused write sets it; writing a one to its bit clears
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ovf_q <= 1'b0;
      end else if (wr_req && !in_rdy) begin
         ovf_q <= 1'b1;
      end else if (reg_we_i && reg_addr_i == ADDR_STATUS && reg_wdata_i[ST_OVF_BIT]) begin
         ovf_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= '0;
         if (reg_re_i) begin
            unique case (reg_addr_i)
               ADDR_MODE: rdata_q[3:0] <= mode_q;
               ADDR_STATUS: begin
                  rdata_q[ST_CTL_LSB +: CTL_W] <= ctl_s2_q; // R15
                  rdata_q[ST_STATE_LSB +: 3] <= state_code(st_q);
                  rdata_q[ST_OVF_BIT] <= ovf_q;
                  rdata_q[ST_RXEN_BIT] <= rxen_q;
               end
               ADDR_LEVEL: rdata_q[LVL_W-1:0] <= lvl;
               default: rdata_q <= '0;
            endcase
         end
      end
   end

   assign reg_rdata_o = rdata_q;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_pull_enter;
      st_q == ST_PULL ##1 st_q == ST_PULL_LOW;
   endsequence

   sequence s_permit_start;
      !permit_out_o ##1 permit_out_o;
   endsequence

   chk_permit_width: assert property (s_permit_start |-> permit_out_o[*8] ##1 !permit_out_o) // R11
      else $error("permit out pulse width wrong");
   chk_free_noperm: assert property ((mode_q == MODE_TOKEN_FREE)[*2] |-> !permit_out_o) // R12
      else $error("permit out in token free mode");
   chk_strobe_word: assert property (st_q == ST_XFER && strb_fall |-> wr_req && wr_data == data_s2_q) // R5
      else $error("strobe edge did not write");
   chk_eor_marker: assert property (st_q == ST_XFER && eor_rise && mode_q != MODE_RAW && !mode_wr
      |-> ##[1:3] (wr_req && wr_data == EOR_MARK)) // R6
      else $error("end of record marker missing");
   chk_wait_permit: assert property (st_q == ST_WAIT && !permit_rise && !mode_wr |=> st_q == ST_WAIT) // R7
      else $error("left wait without permit in");
   chk_pull_strobe: assert property (disable iff (!resetn_i || mode_wr)
      s_pull_enter |=> strobe_o[*8] ##1 !strobe_o) // R8
      else $error("pull strobe timing wrong");
   chk_pull_stop: assert property (st_q == ST_PULL && empty_s && !mode_wr |=> st_q == ST_HOLD) // R9
      else $error("pull did not stop on empty");
   chk_camac_only: assert property (!rx_on(mode_q) && mode_q != MODE_LOOPBACK && $past(mode_q) == mode_q
      |-> wr_req == cam_wr ##1 !rx_enable_o) // R10 R19
      else $error("link write or receivers in disabled mode");
   chk_loop_dup: assert property (wr_req && st_q == ST_LOOP |-> wr_data[31:16] == wr_data[15:0]) // R14
      else $error("loopback halves differ");
   chk_raw_nowait: assert property ((mode_q == MODE_RAW)[*2] |-> !wait_o) // R15
      else $error("wait driven in raw mode");
   chk_single_hold: assert property (st_q == ST_HOLD && mode_q == MODE_SINGLE_GRANT && !mode_wr
      |=> st_q == ST_HOLD ##1 !permit_out_o) // R16
      else $error("single grant mode left hold");
endmodule : ripc_ctrl

// [sim/ripc_src_model.sv]
// link-side data source model: token strobes, end of record, permit, pull replies
// assumes the bench calls its tasks and the dut drives the pull strobe
`timescale 1ns/10ps
module ripc_src_model (
   input wire logic pull_strobe_i,
   output logic [31:0] data_o,
   output logic strobe_o,
   output logic eor_o,
   output logic permit_o,
   output logic empty_o
);
   int left = 0;
   logic [31:0] next_w = 32'h0;
   initial begin
      data_o = 32'h0;
      strobe_o = 1'h1;
      eor_o = 1'h0;
      permit_o = 1'h0;
      empty_o = 1'h1;
   end
   // one word per 400 ns; the word is inverted once its hold is over,
   // so a late sample shows up as wrong data instead of a lucky match
   task automatic send(input logic [31:0] w);
      data_o = w;
      #200 strobe_o = 1'h0;
      #150 data_o = ~w;
      #50 strobe_o = 1'h1;
   endtask : send
   task automatic end_of_record();
      eor_o = 1'h1;
      #400 eor_o = 1'h0;
   endtask : end_of_record
   task automatic permit();
      permit_o = 1'h1;
      #400 permit_o = 1'h0;
   endtask : permit
   task automatic load(input int n, input logic [31:0] w);
      next_w = w;
      left = n;
      empty_o = (n == 0);
   endtask : load
   // pull reply: word while strobe is high, empty updated as it ends
   always @(posedge pull_strobe_i) data_o = next_w;
   always @(negedge pull_strobe_i) begin
      next_w = next_w + 32'h1;
      left = left - 1;
      empty_o = (left <= 0);
   end
endmodule : ripc_src_model

// [sim/ripc_ctrl_tb.sv]
// self-checking bench for ripc_ctrl with a link source model
// assumes ripc_src_model drives the link pins; bus and ecl run on ref_clk_i
`timescale 1ns/10ps
module ripc_ctrl_tb import ripc_pkg::*; ();
   // ----------
   // signals
   // ----------
   typedef struct packed {
      logic [3:0] m;
      logic rx;
      logic [3:0] pc;
   } ripc_row_s;
   localparam ripc_row_s ROWS [16] = '{
      '{4'h0, 1'h0, 4'h0}, '{4'h1, 1'h1, 4'h8}, '{4'h2, 1'h1, 4'h0}, '{4'h3, 1'h1, 4'h0},
      '{4'h4, 1'h0, 4'h0}, '{4'h5, 1'h1, 4'h8}, '{4'h6, 1'h0, 4'h0}, '{4'h7, 1'h0, 4'h0},
      '{4'h8, 1'h1, 4'h8}, '{4'h9, 1'h0, 4'h0}, '{4'hA, 1'h0, 4'h0}, '{4'hB, 1'h0, 4'h0},
      '{4'hC, 1'h0, 4'h0}, '{4'hD, 1'h0, 4'h0}, '{4'hE, 1'h0, 4'h0}, '{4'hF, 1'h0, 4'h0}
   };
   logic clk = 1'h0;
   logic rst_n, we, re, rdy, ecl_v;
   logic pstb_q = 1'h0;
   logic [3:0] addr, aux;
   logic [31:0] wdata;
   logic [15:0] ecl_d;
   logic [31:0] rdata, sdata, fdata, v;
   logic stb, end_of_record, prm, emp, pstb, pout, wt, rxen, erdy, fval;
   int miscompares = 0;
   int checks_done = 0;
   int pc = 0;
   int pr = 0;
   int n;

   initial forever #25 clk = ~clk;

   ripc_ctrl dut_u (
      .ref_clk_i(clk), .resetn_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .src_data_i(sdata),
      .src_strobe_i(stb), .end_of_record_i(end_of_record), .permit_in_i(prm),
      .source_empty_flag_i(emp), .aux_ctrl_i(aux), .strobe_o(pstb), .permit_out_o(pout),
      .wait_o(wt), .rx_enable_o(rxen), .ecl_data_i(ecl_d), .ecl_valid_i(ecl_v),
      .ecl_ready_o(erdy), .fifo_rd_data_o(fdata), .fifo_rd_valid_o(fval),
      .fifo_rd_ready_i(rdy)
   );
   ripc_src_model src_u (
      .pull_strobe_i(pstb), .data_o(sdata), .strobe_o(stb), .eor_o(end_of_record),
      .permit_o(prm), .empty_o(emp)
   );

   // permit high cycles and pull strobe pulses, counted at the settled edge
   always @(negedge clk) begin
      if (pout === 1'h1) pc++;
      if (pstb === 1'h1 && pstb_q !== 1'h1) pr++;
      pstb_q = pstb;
   end

   // ----------
   // tasks
   // ----------
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done
   // compares at the falling edge so outputs have settled
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      @(negedge clk);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      we <= 1'h1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      we <= 1'h0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] q);
      @(posedge clk);
      re <= 1'h1;
      addr <= a;
      @(posedge clk);
      re <= 1'h0;
      @(negedge clk);
      q = rdata;
   endtask : rd
   // one-cycle ready after a stall, so the head is always held a while
   task automatic pop(input logic [31:0] e);
      int k;
      k = 0;
      @(negedge clk);
      while (fval !== 1'h1 && k < 200) begin
         @(negedge clk);
         k++;
      end
      if (k >= 200) begin
         miscompares++;
         $display("BAD %0t no word", $time);
         test_done();
      end
      chk(fdata, e);
      @(posedge clk);
      rdy <= 1'h1;
      @(posedge clk);
      rdy <= 1'h0;
      @(negedge clk);
   endtask : pop

   initial begin
      #3_000_000;
      miscompares++;
      $display("BAD %0t watchdog", $time);
      test_done();
   end

   // ----------
   // sequence
   // ----------
   initial begin
      rst_n = 1'h0;
      we = 1'h0;
      re = 1'h0;
      rdy = 1'h0;
      ecl_v = 1'h0;
      addr = 4'h0;
      aux = 4'hA;
      wdata = 32'h0;
      ecl_d = 16'h5A3C;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      cyc(2);
      rd(ADDR_MODE, v);
      chk(v, 32'h0);
      rd(4'h2, v);
      chk(v, 32'h0);
      chk({rxen, pout, fval}, 3'h0);
      $display("reset test done");
      for (int i = 0; i < 16; i++) begin
         wr(ADDR_MODE, {28'h0, ROWS[i].m});
         pc = 0;
         pr = 0;
         cyc(24);
         chk(rxen, ROWS[i].rx);
         chk(pc, ROWS[i].pc);
         chk(pr, 0);
         rd(ADDR_MODE, v);
         chk(v[3:0], ROWS[i].m);
      end
      $display("mode table done");
      wr(ADDR_MODE, 32'h0);
      wr(ADDR_WDATA, 32'h1234_5678);
      wr(ADDR_WDATA, 32'hCAFE_0001);
      cyc(4);
      rd(ADDR_LEVEL, v);
      chk(v, 32'h1);
      pop(32'h1234_5678);
      pop(32'hCAFE_0001);
      wr(ADDR_MODE, 32'h6);
      wr(ADDR_WDATA, 32'h0000_0066);
      cyc(8);
      chk(fval, 1'h0);
      $display("register write test done");
      wr(ADDR_MODE, 32'h1);
      cyc(24);
      src_u.send(32'hA000_0001);
      src_u.send(32'hA000_0002);
      src_u.end_of_record();
      pop(32'hA000_0001);
      pop(32'hA000_0002);
      pop(EOR_MARK);
      rd(ADDR_STATUS, v);
      chk(v[10:8], 3'h2);
      src_u.send(32'hA000_0003);
      cyc(8);
      chk(fval, 1'h0);
      pc = 0;
      src_u.permit();
      cyc(40);
      chk(pc, 8);
      src_u.send(32'hA000_0004);
      pop(32'hA000_0004);
      $display("permit mode test done");
      wr(ADDR_MODE, 32'h2);
      pc = 0;
      cyc(24);
      src_u.send(32'hB000_0001);
      src_u.end_of_record();
      src_u.send(32'hB000_0002);
      src_u.permit();
      pop(32'hB000_0001);
      pop(EOR_MARK);
      pop(32'hB000_0002);
      chk(pc, 0);
      $display("free mode test done");
      @(posedge clk);
      aux <= 4'h5;
      wr(ADDR_MODE, 32'h5);
      cyc(24);
      src_u.send(32'hC000_0001);
      src_u.end_of_record();
      pop(32'hC000_0001);
      chk(fval, 1'h0);
      rd(ADDR_STATUS, v);
      chk(v[7:0], 8'h5C);
      $display("raw mode test done");
      wr(ADDR_MODE, 32'h8);
      cyc(24);
      src_u.send(32'hD000_0001);
      src_u.end_of_record();
      pop(32'hD000_0001);
      pop(EOR_MARK);
      pc = 0;
      src_u.permit();
      cyc(40);
      chk(pc, 0);
      src_u.send(32'hD000_0002);
      cyc(8);
      chk(fval, 1'h0);
      wr(ADDR_MODE, 32'h0);
      wr(ADDR_MODE, 32'h8);
      cyc(24);
      chk(pc, 8);
      $display("single grant test done");
      src_u.load(3, 32'h0000_0100);
      pr = 0;
      wr(ADDR_MODE, 32'h3);
      for (int i = 0; i < 3; i++) pop(32'h100 + i);
      cyc(60);
      chk(pr, 3);
      chk(fval, 1'h0);
      $display("pull mode test done");
      @(posedge clk);
      ecl_v <= 1'h1;
      ecl_d <= 16'hC3A5;
      wr(ADDR_MODE, 32'h4);
      pop({ecl_d, ecl_d});
      wr(ADDR_MODE, 32'h0);
      ecl_v <= 1'h0;
      cyc(3);
      chk(erdy, 1'h0);
      n = 0;
      while (fval === 1'h1 && n < 99) begin
         pop({ecl_d, ecl_d});
         n++;
      end
      $display("loopback test done");
      for (int i = 0; i < 4100; i++) wr(ADDR_WDATA, 32'(i));
      rd(ADDR_STATUS, v);
      chk(v[11], 1'h1);
      wr(ADDR_STATUS, 32'h800);
      rd(ADDR_STATUS, v);
      chk(v[11], 1'h0);
      wr(ADDR_MODE, 32'h1);
      cyc(30);
      chk(wt, 1'h1);
      wr(ADDR_MODE, 32'h5);
      cyc(30);
      chk(wt, 1'h0);
      wr(ADDR_MODE, 32'h0);
      @(negedge clk);
      n = 0;
      while (fval === 1'h1 && n < 5000) begin
         pop(32'(n));
         n++;
      end
      chk(n >= FIFO_DEPTH && n <= FIFO_DEPTH + 1, 1'h1);
      $display("fill and drain test done");
      wr(ADDR_MODE, 32'h1);
      cyc(5);
      rst_n <= 1'h0;
      cyc(3);
      chk({pout, rxen}, 2'h0);
      @(posedge clk);
      rst_n <= 1'h1;
      cyc(2);
      rd(ADDR_MODE, v);
      chk(v, 32'h0);
      $display("second reset test done");
      test_done();
   end
endmodule : ripc_ctrl_tb
